// ### bcw_pkg.sv
/*
  Constants, register map and state encoding for the boot configuration
  word decoder. Assumes a 50 MHz core clock and a 32-bit AHB-Lite bus.
*/
// Behaviour
// - Averaging field bits 23:21 holds n; average 2**n angle samples per output.
// - Each averaging code doubles samples and period; code 000 is one sample per 31.25 us.
// - After boot, averaging setting is read and changed by extended command 0xFFD0.
// - Rate word bit 20 low runs the working memory self-test every boot.
// - Enabled memory self-test holds off first angle for about 100 us.
// - Function pulse adjust bits 19:18 apply only when line protocol mode is 7.
// - Function pulse is valid only if at least 9 ticks plus adjust long.
// - Bits 17:16 give highest sensor index; slot counter wraps to zero after it.
// - Highest index 0 means one sensor alone; 1 to 3 mean two to four sharing.
// - Own sensor index comes from the two address select pins.
// - Diag word bit 23 high lets request or override pulses start the Hall self-test.
// - Diag word bit 22 low runs the Hall self-test at boot, about 36 ms.
// - Diag word bit 21 low runs the ROM checksum at boot, about 4.5 ms.
// - Diag word bit 20 high enables CRC checking on SPI input data.
// - Harmonic limit above 13 reuses the CRC bit to seed the harmonic phase field.
// - Harmonic limit bits 19:16 seed the working harmonic limit.
// - Bits 15:0 of each word seed the matching working filter numerator.
// - Filter error value field seeds the working filter error field.
package bcw_pkg;
  localparam logic [11:0] BCW_IDX_FILT  = 12'h307;
  localparam logic [11:0] BCW_IDX_RATE  = 12'h308;
  localparam logic [11:0] BCW_IDX_DIAG  = 12'h309;
  localparam logic [11:0] BCW_IDX_CTRL  = 12'h310;
  localparam logic [11:0] BCW_IDX_STAT  = 12'h311;
  localparam logic [11:0] BCW_IDX_EXT   = 12'h312;
  localparam logic [23:0] BCW_RST_FILT  = 24'h0000AA;
  localparam logic [23:0] BCW_RST_RATE  = 24'h000156;
  localparam logic [23:0] BCW_RST_DIAG  = 24'h0000AB;
  localparam int AVG_HI = 23;
  localparam int AVG_LO = 21;
  localparam int MEM_SKIP_BIT = 20;
  localparam int FP_HI = 19;
  localparam int FP_LO = 18;
  localparam int ID_HI = 17;
  localparam int ID_LO = 16;
  localparam int UI_BIT = 23;
  localparam int HALL_SKIP_BIT = 22;
  localparam int ROM_SKIP_BIT = 21;
  localparam int CRC_BIT = 20;
  localparam int HI_HI = 19;
  localparam int HI_LO = 16;
  localparam int NUM_HI = 15;
  localparam logic [3:0]  HARM_REUSE_ABOVE = 4'hD;
  localparam logic [2:0]  LONG_PROTOCOL_MODE = 3'h7;
  localparam logic [4:0]  PULSE_MIN_BASE = 5'h09;
  localparam logic [15:0] EXT_AVG_CMD = 16'hFFD0;
  localparam int EXT_WR_BIT = 3;
  localparam int CTRL_REBOOT_BIT = 0;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLE_PERIOD_10NS = 3125;
  localparam int MEM_TEST_NS = 100000;
  localparam int ROM_TEST_NS = 4500000;
  localparam int HALL_TEST_NS = 36000000;
  localparam int SAMPLE_CYC = (SAMPLE_PERIOD_10NS * 10) / CLK_PERIOD_NS;
  localparam int MEM_TEST_CYC = MEM_TEST_NS / CLK_PERIOD_NS;
  localparam int ROM_TEST_CYC = ROM_TEST_NS / CLK_PERIOD_NS;
  localparam int HALL_TEST_CYC = HALL_TEST_NS / CLK_PERIOD_NS;
  typedef enum logic [4:0] {
    BCW_LOAD = 5'h01,
    BCW_MEM  = 5'h02,
    BCW_ROM  = 5'h04,
    BCW_HALL = 5'h08,
    BCW_RUN  = 5'h10
  } bcw_state_e;
endpackage

// ### bcw_boot_config.sv
/*
  Boot configuration word decoder: holds the three configuration words,
  seeds working copies at boot, sequences boot self-tests, averages angle
  samples, qualifies function pulses and tracks the shared bus slot.
  Assumes an AHB-Lite master with single word transfers and inputs that
  are synchronous to core_clk.
*/
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module bcw_boot_config #(
  parameter int MEM_CYC  = bcw_pkg::MEM_TEST_CYC,
  parameter int ROM_CYC  = bcw_pkg::ROM_TEST_CYC,
  parameter int HALL_CYC = bcw_pkg::HALL_TEST_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] angle_in,
  input  wire logic [2:0]  line_protocol_mode,
  input  wire logic        sent_tick_en,
  input  wire logic        fpulse_in,
  input  wire logic        diag_req_pulse,
  input  wire logic        diag_override_pulse,
  input  wire logic        slot_advance,
  input  wire logic        addr_select_pin_zero,
  input  wire logic        addr_select_pin_one,
  output logic      [15:0] angle_avg,
  output logic             angle_avg_valid,
  output logic             boot_done,
  output logic             selftest_busy,
  output logic      [2:0]  output_averaging_code,
  output logic      [3:0]  working_harmonic_limit,
  output logic             harmonic_phase_field,
  output logic      [3:0]  working_filter_error,
  output logic      [15:0] filter_numerator_one,
  output logic      [15:0] filter_numerator_two,
  output logic      [15:0] filter_numerator_three,
  output logic             spi_crc_check_enable,
  output logic             fpulse_valid,
  output logic      [1:0]  slot_count,
  output logic             own_slot_active
);
  typedef struct packed {
    logic [23:0]         w_filt;
    logic [23:0]         w_rate;
    logic [23:0]         w_diag;
    logic                wr_pend;
    logic [11:0]         wr_idx;
    logic [31:0]         rdata;
    logic                ready;
    bcw_pkg::bcw_state_e st;
    logic [20:0]         timer;
    logic                boot_done;
    logic [2:0]          avg_code;
    logic [3:0]          harm_lim;
    logic                harm_phase;
    logic [3:0]          filt_err;
    logic [15:0]         num1;
    logic [15:0]         num2;
    logic [15:0]         num3;
    logic                crc_en;
    logic [1:0]          function_pulse_min_adjust;
    logic [1:0]          max_id;
    logic [1:0]          own_idx;
    logic                ui_en;
    logic [10:0]         div;
    logic                tick;
    logic [22:0]         acc;
    logic [6:0]          acc_cnt;
    logic [15:0]         avg;
    logic                avg_valid;
    logic [4:0]          plen;
    logic                pprev;
    logic                fp_valid;
    logic [1:0]          slot;
    logic                own_slot;
    logic [15:0]         ext_last;
    logic                busy;
  } bcw_state_s;

  bcw_state_s st_ff;
  bcw_state_s nxt_st;

  logic        addr_ok;
  logic [11:0] addr_idx;
  logic [22:0] acc_sum;
  logic [4:0]  pulse_min;
  logic [6:0]  avg_last;

  assign addr_ok  = hsel && htrans[1] && hready;
  assign addr_idx = haddr[13:2];
  assign acc_sum  = st_ff.acc + {7'h00, angle_in};
  // Adjust only counts in the long shared-bus protocol
  assign pulse_min = (line_protocol_mode == bcw_pkg::LONG_PROTOCOL_MODE) ?
                     bcw_pkg::PULSE_MIN_BASE + {3'h0, st_ff.function_pulse_min_adjust} :
                     bcw_pkg::PULSE_MIN_BASE;
  assign avg_last  = 7'((8'h01 << st_ff.avg_code) - 8'h01);

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.tick      = 1'b0;
    nxt_st.avg_valid = 1'b0;
    nxt_st.fp_valid  = 1'b0;
    nxt_st.ready     = 1'b1;

    // Data phase of a write
    if (st_ff.wr_pend) begin
      unique case (st_ff.wr_idx)
        bcw_pkg::BCW_IDX_FILT: nxt_st.w_filt = hwdata[23:0];
        bcw_pkg::BCW_IDX_RATE: nxt_st.w_rate = hwdata[23:0];
        bcw_pkg::BCW_IDX_DIAG: nxt_st.w_diag = hwdata[23:0];
        bcw_pkg::BCW_IDX_CTRL: begin
          if (hwdata[bcw_pkg::CTRL_REBOOT_BIT]) begin
            nxt_st.st        = bcw_pkg::BCW_LOAD;
            nxt_st.boot_done = 1'b0;
          end
        end
        bcw_pkg::BCW_IDX_EXT: begin
          nxt_st.ext_last = hwdata[31:16];
          if (hwdata[31:16] == bcw_pkg::EXT_AVG_CMD && st_ff.boot_done &&
              hwdata[bcw_pkg::EXT_WR_BIT]) begin
            nxt_st.avg_code = hwdata[2:0];
          end
        end
        default: ;
      endcase
    end
    nxt_st.wr_pend = addr_ok && hwrite;
    nxt_st.wr_idx  = addr_idx;

    // Boot sequencer
    unique case (st_ff.st)
      bcw_pkg::BCW_LOAD: begin
        nxt_st.avg_code   = st_ff.w_rate[bcw_pkg::AVG_HI:bcw_pkg::AVG_LO];
        nxt_st.function_pulse_min_adjust     = st_ff.w_rate[bcw_pkg::FP_HI:bcw_pkg::FP_LO];
        nxt_st.max_id     = st_ff.w_rate[bcw_pkg::ID_HI:bcw_pkg::ID_LO];
        nxt_st.own_idx    = {addr_select_pin_one, addr_select_pin_zero};
        nxt_st.ui_en      = st_ff.w_diag[bcw_pkg::UI_BIT];
        nxt_st.harm_lim   = st_ff.w_diag[bcw_pkg::HI_HI:bcw_pkg::HI_LO];
        // CRC bit is converted to a phase seed for large harmonic limits
        if (st_ff.w_diag[bcw_pkg::HI_HI:bcw_pkg::HI_LO] > bcw_pkg::HARM_REUSE_ABOVE) begin
          nxt_st.harm_phase = st_ff.w_diag[bcw_pkg::CRC_BIT];
          nxt_st.crc_en     = 1'b0;
        end else begin
          nxt_st.harm_phase = 1'b0;
          nxt_st.crc_en     = st_ff.w_diag[bcw_pkg::CRC_BIT];
        end
        nxt_st.filt_err   = st_ff.w_filt[bcw_pkg::HI_HI:bcw_pkg::HI_LO];
        nxt_st.num1       = st_ff.w_filt[bcw_pkg::NUM_HI:0];
        nxt_st.num2       = st_ff.w_rate[bcw_pkg::NUM_HI:0];
        nxt_st.num3       = st_ff.w_diag[bcw_pkg::NUM_HI:0];
        nxt_st.timer      = '0;
        nxt_st.acc        = '0;
        nxt_st.acc_cnt    = '0;
        nxt_st.slot       = '0;
        if (!st_ff.w_rate[bcw_pkg::MEM_SKIP_BIT]) begin
          nxt_st.st = bcw_pkg::BCW_MEM;
        end else if (!st_ff.w_diag[bcw_pkg::ROM_SKIP_BIT]) begin
          nxt_st.st = bcw_pkg::BCW_ROM;
        end else if (!st_ff.w_diag[bcw_pkg::HALL_SKIP_BIT]) begin
          nxt_st.st = bcw_pkg::BCW_HALL;
        end else begin
          nxt_st.st        = bcw_pkg::BCW_RUN;
          nxt_st.boot_done = 1'b1;
        end
      end
      bcw_pkg::BCW_MEM: begin
        nxt_st.timer = st_ff.timer + 21'h000001;
        if (st_ff.timer == 21'(MEM_CYC - 1)) begin
          nxt_st.timer = '0;
          if (!st_ff.w_diag[bcw_pkg::ROM_SKIP_BIT]) begin
            nxt_st.st = bcw_pkg::BCW_ROM;
          end else if (!st_ff.w_diag[bcw_pkg::HALL_SKIP_BIT]) begin
            nxt_st.st = bcw_pkg::BCW_HALL;
          end else begin
            nxt_st.st        = bcw_pkg::BCW_RUN;
            nxt_st.boot_done = 1'b1;
          end
        end
      end
      bcw_pkg::BCW_ROM: begin
        nxt_st.timer = st_ff.timer + 21'h000001;
        if (st_ff.timer == 21'(ROM_CYC - 1)) begin
          nxt_st.timer = '0;
          if (!st_ff.w_diag[bcw_pkg::HALL_SKIP_BIT]) begin
            nxt_st.st = bcw_pkg::BCW_HALL;
          end else begin
            nxt_st.st        = bcw_pkg::BCW_RUN;
            nxt_st.boot_done = 1'b1;
          end
        end
      end
      bcw_pkg::BCW_HALL: begin
        nxt_st.timer = st_ff.timer + 21'h000001;
        if (st_ff.timer == 21'(HALL_CYC - 1)) begin
          nxt_st.timer     = '0;
          nxt_st.st        = bcw_pkg::BCW_RUN;
          nxt_st.boot_done = 1'b1;
        end
      end
      bcw_pkg::BCW_RUN: begin
        // Field-triggered Hall test clears the partial average and stops averaging until it ends
        if (st_ff.ui_en && (diag_req_pulse || diag_override_pulse)) begin
          nxt_st.st      = bcw_pkg::BCW_HALL;
          nxt_st.timer   = '0;
          nxt_st.acc     = '0;
          nxt_st.acc_cnt = '0;
        end else if (st_ff.tick) begin
          if (st_ff.acc_cnt == avg_last) begin
            nxt_st.avg       = 16'(acc_sum >> st_ff.avg_code);
            nxt_st.avg_valid = 1'b1;
            nxt_st.acc       = '0;
            nxt_st.acc_cnt   = '0;
          end else begin
            nxt_st.acc     = acc_sum;
            nxt_st.acc_cnt = st_ff.acc_cnt + 7'h01;
          end
        end
      end
    endcase

    // Reboot request overrides whatever the sequencer chose this cycle
    if (st_ff.wr_pend && (st_ff.wr_idx == bcw_pkg::BCW_IDX_CTRL) &&
        hwdata[bcw_pkg::CTRL_REBOOT_BIT]) begin
      nxt_st.st        = bcw_pkg::BCW_LOAD;
      nxt_st.boot_done = 1'b0;
    end
    // Registered so the busy pin comes straight from a flop
    nxt_st.busy = (nxt_st.st != bcw_pkg::BCW_RUN);

    // Base sample rate divider
    if (st_ff.div == 11'(bcw_pkg::SAMPLE_CYC - 1)) begin
      nxt_st.div  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 11'h001;
    end

    // Function pulse width in line ticks, saturating
    nxt_st.pprev = fpulse_in;
    if (fpulse_in) begin
      if (!st_ff.pprev) begin
        nxt_st.plen = '0;
      end else if (sent_tick_en && st_ff.plen != 5'h1F) begin
        nxt_st.plen = st_ff.plen + 5'h01;
      end
    end else if (st_ff.pprev) begin
      nxt_st.fp_valid = (st_ff.plen >= pulse_min);
    end

    if (slot_advance) begin
      nxt_st.slot = (st_ff.slot == st_ff.max_id) ? 2'h0 : st_ff.slot + 2'h1;
    end
    nxt_st.own_slot = (nxt_st.slot == st_ff.own_idx);

    // Read data after any write of this cycle so back-to-back reads see it
    nxt_st.rdata = '0;
    if (addr_ok && !hwrite) begin
      unique case (addr_idx)
        bcw_pkg::BCW_IDX_FILT: nxt_st.rdata = {8'h00, nxt_st.w_filt};
        bcw_pkg::BCW_IDX_RATE: nxt_st.rdata = {8'h00, nxt_st.w_rate};
        bcw_pkg::BCW_IDX_DIAG: nxt_st.rdata = {8'h00, nxt_st.w_diag};
        bcw_pkg::BCW_IDX_STAT: nxt_st.rdata = {18'h00000, st_ff.own_idx, st_ff.slot,
                                               st_ff.max_id, st_ff.function_pulse_min_adjust,
                                               st_ff.boot_done, st_ff.st};
        bcw_pkg::BCW_IDX_EXT:  nxt_st.rdata = {nxt_st.ext_last, 13'h0000,
                                               nxt_st.avg_code};
        default:               nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff        <= '0;
      st_ff.w_filt <= bcw_pkg::BCW_RST_FILT;
      st_ff.w_rate <= bcw_pkg::BCW_RST_RATE;
      st_ff.w_diag <= bcw_pkg::BCW_RST_DIAG;
      st_ff.ready  <= 1'b1;
      st_ff.busy   <= 1'b1;
      st_ff.st     <= bcw_pkg::BCW_LOAD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata                 = st_ff.rdata;
  assign hreadyout              = st_ff.ready;
  assign hresp                  = 1'b0;
  assign angle_avg              = st_ff.avg;
  assign angle_avg_valid        = st_ff.avg_valid;
  assign boot_done              = st_ff.boot_done;
  assign selftest_busy          = st_ff.busy;
  assign output_averaging_code  = st_ff.avg_code;
  assign working_harmonic_limit = st_ff.harm_lim;
  assign harmonic_phase_field   = st_ff.harm_phase;
  assign working_filter_error   = st_ff.filt_err;
  assign filter_numerator_one   = st_ff.num1;
  assign filter_numerator_two   = st_ff.num2;
  assign filter_numerator_three = st_ff.num3;
  assign spi_crc_check_enable   = st_ff.crc_en;
  assign fpulse_valid           = st_ff.fp_valid;
  assign slot_count             = st_ff.slot;
  assign own_slot_active        = st_ff.own_slot;

  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_all_skip_run: assert property ((st_ff.st == bcw_pkg::BCW_LOAD) &&
      st_ff.w_rate[bcw_pkg::MEM_SKIP_BIT] && st_ff.w_diag[bcw_pkg::ROM_SKIP_BIT] &&
      st_ff.w_diag[bcw_pkg::HALL_SKIP_BIT] && !st_ff.wr_pend
      |=> (st_ff.st == bcw_pkg::BCW_RUN) && st_ff.boot_done)
    else $error("skipped tests did not go straight to run");
  a_mem_hold: assert property ((st_ff.st == bcw_pkg::BCW_MEM) &&
      (st_ff.timer < 21'(MEM_CYC - 1)) && !st_ff.wr_pend |=> (st_ff.st == bcw_pkg::BCW_MEM))
    else $error("memory test ended early");
  a_avg_after_boot: assert property (st_ff.avg_valid |-> st_ff.boot_done)
    else $error("averaged angle before boot done");
  a_avg_on_tick: assert property (st_ff.avg_valid |-> $past(st_ff.tick))
    else $error("averaged angle without a sample tick");
  a_ext_avg_write: assert property (st_ff.wr_pend && (st_ff.wr_idx == bcw_pkg::BCW_IDX_EXT) &&
      (hwdata[31:16] == bcw_pkg::EXT_AVG_CMD) && hwdata[bcw_pkg::EXT_WR_BIT] &&
      st_ff.boot_done |=> st_ff.avg_code == $past(hwdata[2:0]))
    else $error("extended averaging write not applied");
  a_slot_wrap: assert property (slot_advance && (st_ff.slot == st_ff.max_id) &&
      (st_ff.st != bcw_pkg::BCW_LOAD) |=> st_ff.slot == 2'h0)
    else $error("slot counter did not wrap");
  a_fpulse_min: assert property (st_ff.fp_valid |-> $past(st_ff.plen) >=
      ($past(line_protocol_mode) == bcw_pkg::LONG_PROTOCOL_MODE ?
       bcw_pkg::PULSE_MIN_BASE + {3'h0, $past(st_ff.function_pulse_min_adjust)} : bcw_pkg::PULSE_MIN_BASE))
    else $error("short function pulse accepted");
  a_diag_gate: assert property ((st_ff.st == bcw_pkg::BCW_RUN) && !st_ff.ui_en &&
      !st_ff.wr_pend |=> st_ff.st == bcw_pkg::BCW_RUN)
    else $error("diagnostic pulse acted while disabled");
  a_harm_seed: assert property ((st_ff.st == bcw_pkg::BCW_LOAD) |=>
      st_ff.harm_phase == ($past(st_ff.w_diag[bcw_pkg::HI_HI:bcw_pkg::HI_LO]) >
      bcw_pkg::HARM_REUSE_ABOVE && $past(st_ff.w_diag[bcw_pkg::CRC_BIT])))
    else $error("harmonic phase seed wrong");

  // Working copies must follow the words as they stood during LOAD
  a_crc_seed: assert property ((st_ff.st == bcw_pkg::BCW_LOAD) |=>
      st_ff.crc_en == ($past(st_ff.w_diag[bcw_pkg::HI_HI:bcw_pkg::HI_LO]) <=
      bcw_pkg::HARM_REUSE_ABOVE && $past(st_ff.w_diag[bcw_pkg::CRC_BIT])))
    else $error("crc enable seed wrong");
  a_num_seed: assert property ((st_ff.st == bcw_pkg::BCW_LOAD) |=>
      (st_ff.num1 == $past(st_ff.w_filt[bcw_pkg::NUM_HI:0])) &&
      (st_ff.num2 == $past(st_ff.w_rate[bcw_pkg::NUM_HI:0])) &&
      (st_ff.num3 == $past(st_ff.w_diag[bcw_pkg::NUM_HI:0])))
    else $error("filter numerator seed wrong");
  a_lim_seed: assert property ((st_ff.st == bcw_pkg::BCW_LOAD) |=>
      (st_ff.harm_lim == $past(st_ff.w_diag[bcw_pkg::HI_HI:bcw_pkg::HI_LO])) &&
      (st_ff.filt_err == $past(st_ff.w_filt[bcw_pkg::HI_HI:bcw_pkg::HI_LO])))
    else $error("limit or error field seed wrong");
  // Test states may only be left when their timers run out or on a reboot write
  a_rom_hold: assert property ((st_ff.st == bcw_pkg::BCW_ROM) &&
      (st_ff.timer < 21'(ROM_CYC - 1)) && !st_ff.wr_pend |=> (st_ff.st == bcw_pkg::BCW_ROM))
    else $error("rom check ended early");
  a_hall_hold: assert property ((st_ff.st == bcw_pkg::BCW_HALL) &&
      (st_ff.timer < 21'(HALL_CYC - 1)) && !st_ff.wr_pend |=> (st_ff.st == bcw_pkg::BCW_HALL))
    else $error("hall test ended early");

  c_boot_run: cover property ($rose(st_ff.boot_done));
  c_avg_out: cover property (st_ff.avg_valid && st_ff.avg_code != 3'h0);
  c_diag_run: cover property ((st_ff.st == bcw_pkg::BCW_RUN) ##1 (st_ff.st == bcw_pkg::BCW_HALL));
  c_pulse_ok: cover property (st_ff.fp_valid);
  c_slot_wrap: cover property (slot_advance && (st_ff.slot == st_ff.max_id) &&
      (st_ff.max_id != 2'h0));
endmodule

// ### bcw_ahb_host.sv
/*
  AHB-Lite host model: issues single word transfers to the decoder.
  Assumes one slave whose hreadyout comes back as hready.
*/
`timescale 1ns/10ps
module bcw_ahb_host (
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  int hang_cnt = 0;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) hang_cnt++;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) hang_cnt++;
    rd = hrdata;
    // Released data must not look like a held value
    hwdata <= ~wd;
  endtask
endmodule

// ### bcw_boot_config_tb_top.sv
/*
  Self-checking bench for the boot configuration word decoder.
  Assumes short self-test parameters and the host model on the bus.
*/
`timescale 1ns/10ps
module bcw_boot_config_tb_top;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel, hwrite, hready, hresp, sent_tick_en, fpulse_in;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, slot_count;
  logic [2:0]  hsize, line_protocol_mode, output_averaging_code;
  logic [15:0] angle_in, angle_avg, filter_numerator_one, filter_numerator_two;
  logic [15:0] filter_numerator_three;
  logic        diag_req_pulse, diag_override_pulse, slot_advance;
  logic        addr_select_pin_zero, addr_select_pin_one, angle_avg_valid, boot_done;
  logic        selftest_busy, harmonic_phase_field, spi_crc_check_enable;
  logic        fpulse_valid, own_slot_active;
  logic [3:0]  working_harmonic_limit, working_filter_error;
  int          num_errors = 0;
  int          tests_run = 0;

  always #10 core_clk = ~core_clk;

  bcw_ahb_host u_host (.core_clk(core_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  bcw_boot_config #(.MEM_CYC(4), .ROM_CYC(6), .HALL_CYC(8)) u_dut (.core_clk(core_clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .angle_in(angle_in), .line_protocol_mode(line_protocol_mode),
    .sent_tick_en(sent_tick_en), .fpulse_in(fpulse_in), .diag_req_pulse(diag_req_pulse),
    .diag_override_pulse(diag_override_pulse), .slot_advance(slot_advance),
    .addr_select_pin_zero(addr_select_pin_zero), .addr_select_pin_one(addr_select_pin_one),
    .angle_avg(angle_avg), .angle_avg_valid(angle_avg_valid), .boot_done(boot_done),
    .selftest_busy(selftest_busy), .output_averaging_code(output_averaging_code),
    .working_harmonic_limit(working_harmonic_limit),
    .harmonic_phase_field(harmonic_phase_field), .working_filter_error(working_filter_error),
    .filter_numerator_one(filter_numerator_one), .filter_numerator_two(filter_numerator_two),
    .filter_numerator_three(filter_numerator_three),
    .spi_crc_check_enable(spi_crc_check_enable), .fpulse_valid(fpulse_valid),
    .slot_count(slot_count), .own_slot_active(own_slot_active));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_host.xfer(1'b0, a, 32'h5A5A5A5A, r);
    chk(r, e);
  endtask

  // Cycles from busy rising until selftest_busy falls
  task automatic boot_len(output int n);
    int k;
    k = 0;
    n = 0;
    while (selftest_busy !== 1'b1 && k < 8) begin
      @(posedge core_clk);
      k++;
    end
    // Busy also covers a triggered Hall test, where boot_done stays high
    while (selftest_busy !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100) num_errors++;
  endtask

  // Cycles between two output refreshes
  task automatic period(output int p);
    int k;
    k = 0;
    p = 0;
    while (angle_avg_valid !== 1'b1 && k < 9000) begin
      @(posedge core_clk);
      k++;
    end
    do begin
      @(posedge core_clk);
      p++;
    end while (angle_avg_valid !== 1'b1 && p < 9000);
  endtask

  // No angle output while any boot test runs
  always @(posedge core_clk) begin
    if (angle_avg_valid === 1'b1) chk(boot_done, 1'b1);
  end

  task automatic t_reset();
    int n;
    boot_len(n);
    chk(n >= 17 && n <= 22, 1'b1);
    rdc(32'h00000C20, 32'h00000156);
    rdc(32'h00000C24, 32'h000000AB);
    rdc(32'h00000C1C, 32'h000000AA);
    rdc(32'h00000C28, 32'h00000000);
    chk(filter_numerator_two, 16'h0156);
    chk(spi_crc_check_enable, 1'b0);
  endtask

  task automatic t_config();
    int n;
    // Same index limit and adjust as bus peers
    wr(32'h00000C20, 32'h002EBEEF);
    wr(32'h00000C24, 32'h00FE1357);
    wr(32'h00000C1C, 32'h00052468);
    rdc(32'h00000C20, 32'h002EBEEF);
    chk(filter_numerator_two, 16'h0156);
    wr(32'h00000C40, 32'h00000001);
    boot_len(n);
    chk(n >= 3 && n <= 7, 1'b1);
    chk({filter_numerator_one, filter_numerator_two}, 32'h2468BEEF);
    chk(filter_numerator_three, 16'h1357);
    chk(working_filter_error, 4'h5);
    chk(working_harmonic_limit, 4'hE);
    chk({harmonic_phase_field, spi_crc_check_enable}, 2'h2);
    chk(output_averaging_code, 3'h1);
  endtask

  task automatic t_average();
    int p;
    period(p);
    chk(p, 3124);
    chk(angle_avg, 16'h1234);
    wr(32'h00000C48, 32'hFFD0000A);
    rdc(32'h00000C48, 32'hFFD00002);
    chk(output_averaging_code, 3'h2);
    period(p);
    period(p);
    chk(p, 6248);
    wr(32'h00000C48, 32'h1234000F);
    rdc(32'h00000C48, 32'h12340002);
  endtask

  task automatic t_pulse();
    logic [2:0] md [4] = '{3'h7, 3'h7, 3'h0, 3'h0};
    int         wd [4] = '{11, 12, 8, 9};
    logic       ex [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic       seen;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      line_protocol_mode <= md[i];
      fpulse_in <= 1'b1;
      repeat (wd[i]) begin
        @(posedge core_clk);
        sent_tick_en <= 1'b1;
        @(posedge core_clk);
        sent_tick_en <= 1'b0;
      end
      @(posedge core_clk);
      fpulse_in <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        @(posedge core_clk);
        seen = seen | fpulse_valid;
      end
      chk(seen, ex[i]);
    end
  endtask

  task automatic t_slot();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      slot_advance <= 1'b1;
      @(posedge core_clk);
      slot_advance <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(slot_count, (i + 1) % 3);
      chk(own_slot_active, ((i + 1) % 3) == 2);
    end
    rdc(32'h00000C44, 32'h000022F0);
  endtask

  task automatic t_diag();
    int n;
    @(posedge core_clk);
    diag_req_pulse <= 1'b1;
    @(posedge core_clk);
    diag_req_pulse <= 1'b0;
    boot_len(n);
    chk(n >= 7 && n <= 11, 1'b1);
    @(posedge core_clk);
    diag_override_pulse <= 1'b1;
    @(posedge core_clk);
    diag_override_pulse <= 1'b0;
    boot_len(n);
    chk(n >= 7 && n <= 11, 1'b1);
    wr(32'h00000C24, 32'h00731357);
    wr(32'h00000C20, 32'h003EBEEF);
    wr(32'h00000C40, 32'h00000001);
    boot_len(n);
    chk(n <= 3, 1'b1);
    chk({harmonic_phase_field, spi_crc_check_enable}, 2'h1);
    chk(working_harmonic_limit, 4'h3);
    @(posedge core_clk);
    diag_req_pulse <= 1'b1;
    @(posedge core_clk);
    diag_req_pulse <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(selftest_busy, 1'b0);
  endtask

  task automatic close_out();
    num_errors += u_host.hang_cnt;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    angle_in = 16'h1234;
    line_protocol_mode = 3'h0;
    sent_tick_en = 1'b0;
    fpulse_in = 1'b0;
    diag_req_pulse = 1'b0;
    diag_override_pulse = 1'b0;
    slot_advance = 1'b0;
    addr_select_pin_zero = 1'b0;
    addr_select_pin_one = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_config();
    t_average();
    t_pulse();
    t_slot();
    t_diag();
    close_out();
  end
endmodule
